// file: verification/smp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smp_checker (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        memReq,
	input wire logic        memWe,
	input wire logic        memByte,
	input wire logic [19:0] memAddr,
	input wire logic [15:0] memWdata,
	input wire logic        memAck,
	input wire logic        busy
);
	logic        rdSeen_ff;
	logic        wrSeen_ff;
	logic [19:0] lastWr_ff;
	logic [19:0] lastRd_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// per-sequence access history
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n || !busy) begin
			rdSeen_ff <= 1'b0;
			wrSeen_ff <= 1'b0;
		end else if (memReq && memAck && memWe) begin
			wrSeen_ff <= 1'b1;
			lastWr_ff <= memAddr;
		end else if (memReq && memAck) begin
			rdSeen_ff <= 1'b1;
			lastRd_ff <= memAddr;
		end
	end
	sequence s_wrAck; memReq && memWe && memAck; endsequence
	sequence s_rdAck; memReq && !memWe && memAck; endsequence
	property p_req_hold;
		memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata) && $stable(memWe);
	endproperty
	property p_idle_quiet; !busy |-> !memReq; endproperty
	property p_push_desc; s_wrAck ##0 (wrSeen_ff && !rdSeen_ff) |-> memAddr == lastWr_ff - 20'h2;
	endproperty
	property p_no_rd_after_wr; memReq && !memWe |-> !wrSeen_ff; endproperty
	property p_rd_pair; s_rdAck ##0 rdSeen_ff |-> memAddr == lastRd_ff + 20'h2; endproperty
	property p_pop_wr_up; s_wrAck ##0 (wrSeen_ff && rdSeen_ff) |-> memAddr == lastWr_ff + 20'h2;
	endproperty
	property p_byte_pop; memReq && memWe && memByte |-> rdSeen_ff; endproperty
	property p_ar_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
	a_idle_quiet: assert property (p_idle_quiet) else $error("access while idle");
	a_push_desc: assert property (p_push_desc) else $error("push address not two below");
	a_no_rd_after_wr: assert property (p_no_rd_after_wr) else $error("read after write");
	a_rd_pair: assert property (p_rd_pair) else $error("second pop read misplaced");
	a_pop_wr_up: assert property (p_pop_wr_up) else $error("pop high word misplaced");
	a_byte_pop: assert property (p_byte_pop) else $error("byte write outside pop");
	a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	a_aw_block: assert property (p_aw_block) else $error("address taken during response");
endmodule // smp_checker
bind smp_engine smp_checker smp_checker_inst (.*);
`default_nettype wire

// file: verification/smp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module smp_mem_model (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        memReq,
	input wire logic        memWe,
	input wire logic        memByte,
	input wire logic [19:0] memAddr,
	input wire logic [15:0] memWdata,
	output var logic [15:0] memRdata,
	output var logic        memAck
);
	logic [15:0] mem [int];
	// random stalls; read data line toggles when not answering
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memAck <= 1'b0;
			memRdata <= 16'h0000;
		end else if (!memAck && memReq && ($urandom % 3 == 0)) begin
			memAck <= 1'b1;
			if (!memWe)
				memRdata <= mem.exists(memAddr) ? mem[memAddr] : 16'h0000;
			else if (memByte)
				mem[memAddr] = {8'h00, memWdata[7:0]};
			else
				mem[memAddr] = memWdata;
		end else begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
		end
	end
endmodule // smp_mem_model
`default_nettype wire

// file: verification/stack_multi_push_single_pop_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.vh"
module stack_multi_push_single_pop_bench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1;
	logic        s_axi_rready = 1'b1;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire         memReq, memWe, memByte, memAck, busy;
	wire [19:0]  memAddr;
	wire [15:0]  memWdata, memRdata;
	int          num_errors = 0;
	int          compares = 0;
	int          i;
	logic [1:0]  bq [$];
	logic [33:0] rq [$];
	logic [36:0] wq [$];
	logic [19:0] rf [16];
	logic [19:0] sp;
	smp_engine smp_engine_inst (.*);
	smp_mem_model smp_mem_model_inst (.*);
	initial forever #2 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [36:0] e, input logic [36:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tmo(input int t, input int l);
		if (t >= l) begin
			num_errors++;
			end_of_test;
		end
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", bq.size() ? bq.pop_front() : 'x, s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", rq.size() ? rq.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
		if (memReq && memWe && memAck)
			chk("memwr", wq.size() ? wq.pop_front() : 'x,
				{memByte, memAddr, memByte ? {8'h00, memWdata[7:0]} : memWdata});
	end
	task axw(input [7:0] a, input [31:0] d, input [1:0] e);
		logic ad, dd, b;
		int t;
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		b = 1'b0;
		for (t = 0; t < 200 && !b; t++) begin
			@(negedge core_clk);
			ad = s_axi_awvalid && s_axi_awready;
			dd = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge core_clk);
			if (ad) s_axi_awvalid <= 1'b0;
			if (dd) s_axi_wvalid <= 1'b0;
		end
		tmo(t, 200);
	endtask
	task axr(input [7:0] a, input [31:0] d, input [1:0] e);
		logic g, r;
		int t;
		rq.push_back({e, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		r = 1'b0;
		for (t = 0; t < 200 && !r; t++) begin
			@(negedge core_clk);
			g = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			@(posedge core_clk);
			if (g) s_axi_arvalid <= 1'b0;
		end
		tmo(t, 200);
	endtask
	task idle;
		int t;
		for (t = 0; t < 2000; t++) begin
			@(negedge core_clk);
			if (busy === 1'b0) break;
		end
		@(posedge core_clk);
		tmo(t, 2000);
		axr(`SMP_OFF_SP, {12'h000, sp}, `SMP_RESP_OKAY);
		axr(`SMP_OFF_STAT, 32'h0000_0002, `SMP_RESP_OKAY);
	endtask
	task chkreg(input [3:0] r);
		axw(`SMP_OFF_RSEL, {28'h000_0000, r}, `SMP_RESP_OKAY);
		axr(`SMP_OFF_RDAT, {12'h000, rf[r]}, `SMP_RESP_OKAY);
	endtask
	// x asks for writes during the run, which must be refused
	task push(input [1:0] z, input int n, input [3:0] r, input logic x);
		logic [3:0]  k;
		logic [19:0] v;
		for (i = 0; i < n; i++) begin
			k = 4'(r - i);
			sp = sp - (z == 2'h2 ? 20'h4 : 20'h2);
			v = k == 4'h1 ? sp : rf[k];
			if (z == 2'h2) wq.push_back({1'b0, sp + 20'h2, 12'h000, v[19:16]});
			wq.push_back({1'b0, sp, v[15:0]});
		end
		rf[1] = sp;
		axw(`SMP_OFF_CMD, {20'h0_0000, r, n[3:0] - 4'h1, z, 2'h1}, `SMP_RESP_OKAY);
		if (x) begin
			axw(`SMP_OFF_CMD, 32'h0000_0001, `SMP_RESP_SLVERR);
			axw(`SMP_OFF_SP, 32'h0000_0000, `SMP_RESP_SLVERR);
		end
		idle;
	endtask
	task pop(input [1:0] z, input [1:0] m, input [3:0] r);
		logic [15:0] lo, hi;
		logic [19:0] v, ea, d;
		lo = 16'($urandom);
		hi = 16'($urandom);
		d = 20'($urandom);
		smp_mem_model_inst.mem[sp] = lo;
		smp_mem_model_inst.mem[sp + 20'h2] = hi;
		v = z == 2'h2 ? {hi[3:0], lo} : z == 2'h1 ? {4'h0, lo} : {12'h000, lo[7:0]};
		ea = m == 2'h1 ? rf[r] + d : m == 2'h2 ? rf[0] + d : d;
		sp = sp + (z == 2'h2 ? 20'h4 : 20'h2);
		rf[1] = sp;
		if (m == 2'h0) rf[r] = v;
		else begin
			wq.push_back({z == 2'h0, ea, z == 2'h0 ? {8'h00, lo[7:0]} : lo});
			if (z == 2'h2) wq.push_back({1'b0, ea + 20'h2, 12'h000, hi[3:0]});
		end
		axw(`SMP_OFF_DST, {12'h000, d}, `SMP_RESP_OKAY);
		axw(`SMP_OFF_CMD, {18'h0_0000, m, r, 4'h0, z, 2'h2}, `SMP_RESP_OKAY);
		idle;
		chkreg(r);
	endtask
	initial begin
		void'($urandom(32'h65fe_dca5));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		axr(`SMP_OFF_SP, 32'h0000_0000, `SMP_RESP_OKAY);
		axr(`SMP_OFF_STAT, 32'h0000_0000, `SMP_RESP_OKAY);
		for (i = 0; i < 16; i++) rf[i] = 20'($urandom);
		rf[1] = 20'h0_0400;
		sp = rf[1];
		for (int j = 0; j < 16; j++) begin
			axw(`SMP_OFF_RSEL, j, `SMP_RESP_OKAY);
			axw(`SMP_OFF_RDAT, {12'h000, rf[j]}, `SMP_RESP_OKAY);
		end
		push(2'h2, 3, 4'h6, 1'b0);
		push(2'h1, 16, 4'hf, 1'b1);
		push(2'h2, 16, 4'h4, 1'b0);
		push(2'h0, 1, 4'h9, 1'b0);
		for (int j = 0; j < 16; j++) chkreg(j);
		for (int j = 0; j < 12; j++) pop(2'(j % 3), 2'(j / 3), 4'(4 + j));
		for (int j = 0; j < 16; j++) chkreg(j);
		axw(`SMP_OFF_CMD, 32'h0000_0003, `SMP_RESP_OKAY);
		axr(`SMP_OFF_SP, {12'h000, sp}, `SMP_RESP_OKAY);
		axr(8'h40, 32'h0000_0000, `SMP_RESP_SLVERR);
		axw(8'h40, 32'h0000_0000, `SMP_RESP_SLVERR);
		axr(`SMP_OFF_CMD, 32'h0000_0000, `SMP_RESP_OKAY);
		repeat (4) @(posedge core_clk);
		chk("pending", 0, wq.size() + rq.size() + bq.size());
		end_of_test;
	end
endmodule // stack_multi_push_single_pop_bench
`default_nettype wire

// file: verilog/smp_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.vh"

module smp_axil_slave (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        regWrEn,
	output wire [7:0]  regWrAddr,
	output wire [31:0] regWrData,
	output wire [3:0]  regWrStrb,
	input  wire        regWrOk,
	output wire [7:0]  regRdAddr,
	input  wire [31:0] regRdData,
	input  wire        regRdOk
);

	reg        awHeld_ff;
	reg [7:0]  awAddr_ff;
	reg        wHeld_ff;
	reg [31:0] wData_ff;
	reg [3:0]  wStrb_ff;
	reg        bValid_ff;
	reg [1:0]  bResp_ff;
	reg        rValid_ff;
	reg [31:0] rData_ff;
	reg [1:0]  rResp_ff;

	// address and data are caught independently, so either may come first
	assign s_axi_awready = !awHeld_ff && !bValid_ff;
	assign s_axi_wready  = !wHeld_ff && !bValid_ff;
	assign s_axi_arready = !rValid_ff;
	assign s_axi_bvalid  = bValid_ff;
	assign s_axi_bresp   = bResp_ff;
	assign s_axi_rvalid  = rValid_ff;
	assign s_axi_rdata   = rData_ff;
	assign s_axi_rresp   = rResp_ff;
	assign regWrEn       = awHeld_ff && wHeld_ff && !bValid_ff;
	assign regWrAddr     = awAddr_ff;
	assign regWrData     = wData_ff;
	assign regWrStrb     = wStrb_ff;
	assign regRdAddr     = s_axi_araddr;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wHeld_ff  <= 1'b0;
			wData_ff  <= 32'h0000_0000;
			wStrb_ff  <= 4'h0;
			bValid_ff <= 1'b0;
			bResp_ff  <= `SMP_RESP_OKAY;
			rValid_ff <= 1'b0;
			rData_ff  <= 32'h0000_0000;
			rResp_ff  <= `SMP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (regWrEn) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				bValid_ff <= 1'b1;
				bResp_ff  <= regWrOk ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
			end else if (bValid_ff && s_axi_bready) begin
				bValid_ff <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				rValid_ff <= 1'b1;
				rData_ff  <= regRdOk ? regRdData : 32'h0000_0000;
				rResp_ff  <= regRdOk ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
			end else if (rValid_ff && s_axi_rready) begin
				rValid_ff <= 1'b0;
			end
		end
	end

endmodule // smp_axil_slave

`default_nettype wire

// file: verilog/smp_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "smp_map.vh"

module smp_engine (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        memReq,
	output wire        memWe,
	output wire        memByte,
	output wire [19:0] memAddr,
	output wire [15:0] memWdata,
	input  wire [15:0] memRdata,
	input  wire        memAck,
	output wire        busy
);

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_PNXT = 9'h002;
	localparam [8:0] ST_PHI  = 9'h004;
	localparam [8:0] ST_PLO  = 9'h008;
	localparam [8:0] ST_RLO  = 9'h010;
	localparam [8:0] ST_RHI  = 9'h020;
	localparam [8:0] ST_DST  = 9'h040;
	localparam [8:0] ST_WLO  = 9'h080;
	localparam [8:0] ST_WHI  = 9'h100;

	wire        regWrEn;
	wire [7:0]  regWrAddr;
	wire [31:0] regWrData;
	wire [3:0]  regWrStrb;
	wire [7:0]  regRdAddr;
	reg         regWrOk;
	reg  [31:0] regRdData;
	reg         regRdOk;

	reg  [19:0] regFile_ff [0:15];
	reg  [8:0]  state_ff;
	reg  [1:0]  size_ff;
	reg  [1:0]  mode_ff;
	reg  [3:0]  cnt_ff;
	reg  [3:0]  cur_ff;
	reg  [19:0] ea_ff;
	reg  [15:0] lo_ff;
	reg  [3:0]  hi_ff;
	reg         done_ff;
	reg  [3:0]  rsel_ff;
	reg  [19:0] dstOp_ff;
	reg         memReq_ff;
	reg         memWe_ff;
	reg         memByte_ff;
	reg  [19:0] memAddr_ff;
	reg  [15:0] memWdata_ff;

	reg  [8:0]  nxt_state;
	reg  [1:0]  nxt_size;
	reg  [1:0]  nxt_mode;
	reg  [3:0]  nxt_cnt;
	reg  [3:0]  nxt_cur;
	reg  [19:0] nxt_ea;
	reg  [15:0] nxt_lo;
	reg  [3:0]  nxt_hi;
	reg         nxt_done;
	reg         nxt_memReq;
	reg         nxt_memWe;
	reg         nxt_memByte;
	reg  [19:0] nxt_memAddr;
	reg  [15:0] nxt_memWdata;
	reg         rfWe;
	reg  [3:0]  rfIdx;
	reg  [19:0] rfData;
	reg         spWe;
	reg  [19:0] spData;

	wire [19:0] sp      = regFile_ff[`SMP_IDX_SP];
	wire [19:0] curVal  = regFile_ff[cur_ff];
	wire        idle    = state_ff == ST_IDLE;
	wire [31:0] wrOld   = (regWrAddr == `SMP_OFF_DST) ? {12'h000, dstOp_ff} :
	                      (regWrAddr == `SMP_OFF_SP)  ? {12'h000, sp} :
	                      (regWrAddr == `SMP_OFF_SR)  ? {12'h000, regFile_ff[`SMP_IDX_SR]} :
	                      (regWrAddr == `SMP_OFF_RSEL) ? {28'h000_0000, rsel_ff} :
	                      (regWrAddr == `SMP_OFF_RDAT) ? {12'h000, regFile_ff[rsel_ff]} :
	                      32'h0000_0000;
	wire [31:0] wrVal;
	wire        cmdGo   = regWrEn && regWrOk && (regWrAddr == `SMP_OFF_CMD) && idle &&
	                      (wrVal[`SMP_CMD_OP] == `SMP_OP_PUSH || wrVal[`SMP_CMD_OP] == `SMP_OP_POP);
	wire [3:0]  cmdReg  = wrVal[`SMP_CMD_REG];

	assign busy     = !idle;
	assign memReq   = memReq_ff;
	assign memWe    = memWe_ff;
	assign memByte  = memByte_ff;
	assign memAddr  = memAddr_ff;
	assign memWdata = memWdata_ff;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	smp_axil_slave u_bus (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regWrEn       (regWrEn),
		.regWrAddr     (regWrAddr),
		.regWrData     (regWrData),
		.regWrStrb     (regWrStrb),
		.regWrOk       (regWrOk),
		.regRdAddr     (regRdAddr),
		.regRdData     (regRdData),
		.regRdOk       (regRdOk)
	);

	// byte lanes without a strobe keep the old value
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign wrVal[lane*8 +: 8] = regWrStrb[lane] ? regWrData[lane*8 +: 8] :
			                                              wrOld[lane*8 +: 8];
		end
	endgenerate

	// core registers can not change under a running sequence, so those writes are refused
	always @* begin
		case (regWrAddr)
			`SMP_OFF_CMD, `SMP_OFF_SP, `SMP_OFF_SR, `SMP_OFF_RDAT: regWrOk = idle;
			`SMP_OFF_DST, `SMP_OFF_STAT, `SMP_OFF_RSEL:            regWrOk = 1'b1;
			default:                                               regWrOk = 1'b0;
		endcase
	end

	always @* begin
		regRdOk = 1'b1;
		case (regRdAddr)
			`SMP_OFF_CMD:  regRdData = 32'h0000_0000;
			`SMP_OFF_DST:  regRdData = {12'h000, dstOp_ff};
			`SMP_OFF_SP:   regRdData = {12'h000, sp};
			`SMP_OFF_SR:   regRdData = {12'h000, regFile_ff[`SMP_IDX_SR]};
			`SMP_OFF_STAT: regRdData = {30'h0000_0000, done_ff, busy};
			`SMP_OFF_RSEL: regRdData = {28'h000_0000, rsel_ff};
			`SMP_OFF_RDAT: regRdData = {12'h000, regFile_ff[rsel_ff]};
			default: begin
				regRdData = 32'h0000_0000;
				regRdOk   = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always @* begin
		nxt_state    = state_ff;
		nxt_size     = size_ff;
		nxt_mode     = mode_ff;
		nxt_cnt      = cnt_ff;
		nxt_cur      = cur_ff;
		nxt_ea       = ea_ff;
		nxt_lo       = lo_ff;
		nxt_hi       = hi_ff;
		nxt_done     = done_ff;
		nxt_memReq   = memReq_ff;
		nxt_memWe    = memWe_ff;
		nxt_memByte  = memByte_ff;
		nxt_memAddr  = memAddr_ff;
		nxt_memWdata = memWdata_ff;
		rfWe         = 1'b0;
		rfIdx        = cur_ff;
		rfData       = `SMP_RF_RST;
		spWe         = 1'b0;
		spData       = sp;
		case (state_ff)
			ST_IDLE: begin
				// status register changes by software here, or by a register-mode pop into index 2
				// flags left alone
				if (regWrEn && regWrOk && regWrAddr == `SMP_OFF_SP) begin
					rfWe   = 1'b1;
					rfIdx  = `SMP_IDX_SP;
					rfData = wrVal[19:0];
				end else if (regWrEn && regWrOk && regWrAddr == `SMP_OFF_SR) begin
					rfWe   = 1'b1;
					rfIdx  = `SMP_IDX_SR;
					rfData = wrVal[19:0];
				end else if (regWrEn && regWrOk && regWrAddr == `SMP_OFF_RDAT) begin
					rfWe   = 1'b1;
					rfIdx  = rsel_ff;
					rfData = wrVal[19:0];
				end
				if (cmdGo) begin
					nxt_size = wrVal[`SMP_CMD_SIZE];
					nxt_mode = wrVal[`SMP_CMD_MODE];
					nxt_cnt  = wrVal[`SMP_CMD_CNT];
					nxt_cur  = cmdReg;
					nxt_done = 1'b0;
					// two-bit mode has no indirect form
					case (wrVal[`SMP_CMD_MODE])
						`SMP_MD_IDX: nxt_ea = regFile_ff[cmdReg] + dstOp_ff;
						`SMP_MD_SYM: nxt_ea = regFile_ff[`SMP_IDX_PC] + dstOp_ff;
						default:     nxt_ea = dstOp_ff;
					endcase
					if (wrVal[`SMP_CMD_OP] == `SMP_OP_PUSH) begin
						nxt_state = ST_PNXT;
					end else begin
						nxt_memReq  = 1'b1;
						nxt_memWe   = 1'b0;
						nxt_memByte = 1'b0;
						nxt_memAddr = sp;
						nxt_state   = ST_RLO;
					end
				end
			end
			ST_PNXT: begin
				nxt_memReq  = 1'b1;
				nxt_memWe   = 1'b1;
				nxt_memByte = 1'b0;
				spWe        = 1'b1;
				if (size_ff == `SMP_SZ_A) begin
					spData       = sp - `SMP_STEP4;
					nxt_memAddr  = sp - `SMP_STEP2;
					// stack pointer itself is saved already lowered, never torn
					nxt_memWdata = (cur_ff == `SMP_IDX_SP) ? {12'h000, spData[19:16]} :
					                                         {12'h000, curVal[19:16]};
					nxt_state    = ST_PHI;
				end else begin
					spData       = sp - `SMP_STEP2;
					nxt_memAddr  = sp - `SMP_STEP2;
					nxt_memWdata = (cur_ff == `SMP_IDX_SP) ? spData[15:0] : curVal[15:0];
					nxt_state    = ST_PLO;
				end
			end
			ST_PHI: begin
				if (memAck) begin
					nxt_memAddr  = sp;
					nxt_memWdata = curVal[15:0];
					nxt_state    = ST_PLO;
				end
			end
			ST_PLO: begin
				if (memAck) begin
					nxt_memReq = 1'b0;
					if (cnt_ff == 4'h0) begin
						nxt_done  = 1'b1;
						nxt_state = ST_IDLE;
					end else begin
						nxt_cur   = cur_ff - 4'h1;
						nxt_cnt   = cnt_ff - 4'h1;
						nxt_state = ST_PNXT;
					end
				end
			end
			ST_RLO: begin
				if (memAck) begin
					nxt_lo = memRdata;
					if (size_ff == `SMP_SZ_A) begin
						nxt_memAddr = sp + `SMP_STEP2;
						nxt_state   = ST_RHI;
					end else begin
						spWe       = 1'b1;
						spData     = sp + `SMP_STEP2;
						nxt_memReq = 1'b0;
						nxt_state  = ST_DST;
					end
				end
			end
			ST_RHI: begin
				if (memAck) begin
					nxt_hi     = memRdata[3:0];
					spWe       = 1'b1;
					spData     = sp + `SMP_STEP4;
					nxt_memReq = 1'b0;
					nxt_state  = ST_DST;
				end
			end
			ST_DST: begin
				if (mode_ff == `SMP_MD_REG) begin
					// register destination clears unused upper bits
					rfWe = 1'b1;
					case (size_ff)
						`SMP_SZ_A: rfData = {hi_ff, lo_ff};
						`SMP_SZ_W: rfData = {4'h0, lo_ff};
						default:   rfData = {12'h000, lo_ff[7:0]};
					endcase
					nxt_done  = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_memReq   = 1'b1;
					nxt_memWe    = 1'b1;
					nxt_memByte  = size_ff == `SMP_SZ_B;
					nxt_memAddr  = ea_ff;
					nxt_memWdata = lo_ff;
					nxt_state    = ST_WLO;
				end
			end
			ST_WLO: begin
				if (memAck) begin
					if (size_ff == `SMP_SZ_A) begin
						nxt_memAddr  = ea_ff + `SMP_STEP2;
						nxt_memWdata = {12'h000, hi_ff};
						nxt_state    = ST_WHI;
					end else begin
						nxt_memReq = 1'b0;
						nxt_done   = 1'b1;
						nxt_state  = ST_IDLE;
					end
				end
			end
			ST_WHI: begin
				if (memAck) begin
					nxt_memReq = 1'b0;
					nxt_done   = 1'b1;
					nxt_state  = ST_IDLE;
				end
			end
			default: begin
				nxt_memReq = 1'b0;
				nxt_state  = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= ST_IDLE;
			size_ff     <= `SMP_SZ_B;
			mode_ff     <= `SMP_MD_REG;
			cnt_ff      <= 4'h0;
			cur_ff      <= 4'h0;
			ea_ff       <= `SMP_RF_RST;
			lo_ff       <= 16'h0000;
			hi_ff       <= 4'h0;
			done_ff     <= 1'b0;
			rsel_ff     <= 4'h0;
			dstOp_ff    <= `SMP_RF_RST;
			memReq_ff   <= 1'b0;
			memWe_ff    <= 1'b0;
			memByte_ff  <= 1'b0;
			memAddr_ff  <= `SMP_RF_RST;
			memWdata_ff <= 16'h0000;
		end else begin
			state_ff    <= nxt_state;
			size_ff     <= nxt_size;
			mode_ff     <= nxt_mode;
			cnt_ff      <= nxt_cnt;
			cur_ff      <= nxt_cur;
			ea_ff       <= nxt_ea;
			lo_ff       <= nxt_lo;
			hi_ff       <= nxt_hi;
			done_ff     <= nxt_done;
			memReq_ff   <= nxt_memReq;
			memWe_ff    <= nxt_memWe;
			memByte_ff  <= nxt_memByte;
			memAddr_ff  <= nxt_memAddr;
			memWdata_ff <= nxt_memWdata;
			if (regWrEn && regWrAddr == `SMP_OFF_RSEL)
				rsel_ff <= wrVal[3:0];
			if (regWrEn && regWrAddr == `SMP_OFF_DST)
				dstOp_ff <= wrVal[19:0];
		end
	end

	// ----------------------------------------------------------------
	// core register file
	// ----------------------------------------------------------------
	// pushed registers other than the stack pointer are only read, never written
	genvar ent;
	generate
		for (ent = 0; ent < 16; ent = ent + 1) begin : g_rf
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					regFile_ff[ent] <= `SMP_RF_RST;
				else if (rfWe && rfIdx == ent)
					regFile_ff[ent] <= rfData;
				else if (spWe && ent == `SMP_IDX_SP)
					regFile_ff[ent] <= spData;
			end
		end
	endgenerate

endmodule // smp_engine

`default_nettype wire

// file: verilog/smp_map.vh
`ifndef SMP_MAP_VH
`define SMP_MAP_VH

// register offsets (byte addresses)
`define SMP_OFF_CMD     8'h00
`define SMP_OFF_DST     8'h04
`define SMP_OFF_SP      8'h08
`define SMP_OFF_SR      8'h0C
`define SMP_OFF_STAT    8'h10
`define SMP_OFF_RSEL    8'h14
`define SMP_OFF_RDAT    8'h18

// command word fields
`define SMP_CMD_OP      1:0
`define SMP_CMD_SIZE    3:2
`define SMP_CMD_CNT     7:4
`define SMP_CMD_REG     11:8
`define SMP_CMD_MODE    13:12
`define SMP_OP_PUSH     2'h1
`define SMP_OP_POP      2'h2
`define SMP_SZ_B        2'h0
`define SMP_SZ_W        2'h1
`define SMP_SZ_A        2'h2
`define SMP_MD_REG      2'h0
`define SMP_MD_IDX      2'h1
`define SMP_MD_SYM      2'h2
`define SMP_MD_ABS      2'h3

// core register indices, reset value and stack pointer steps
`define SMP_IDX_PC      4'h0
`define SMP_IDX_SP      4'h1
`define SMP_IDX_SR      4'h2
`define SMP_RF_RST      20'h0_0000
`define SMP_STEP2       20'h0_0002
`define SMP_STEP4       20'h0_0004

// bus answers
`define SMP_RESP_OKAY   2'h0
`define SMP_RESP_SLVERR 2'h2

`endif
